/* File: logic/tpc_timer.sv */
// Summary of operation
// R1: Each channel picks capture, compare or edge PWM.
// R2: Center mode counts up/down, all channels PWM.
// R3: One to eight channels, one pin each.
// R4: External clock selectable to drive counter.
// R5: After reset no channel function is enabled.
// R6: Unused channel pins follow port data/direction.
// R7: Center mode overflow at top reversal.
// R8: Capture edge select: none, rise, fall, any.
// R9: Compare flag on every counter/value match.
// R10: Edge PWM flag at end of duty.
// R11: Center PWM flag on both matches.
// R12: Channel flag cleared by read-then-write-zero.
// R13: Counter write clears counter and prescaler.
// R14: Debug mode reads return frozen counter.
// R15: Overflow clear is read then write zero.
// R16: Up mode overflow on modulo to zero.
// R17: External clock synchronised before the prescaler.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module tpc_timer #(
  parameter int NUM_CH = tpc_pkg::TPC_MAX_CH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [tpc_pkg::TPC_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [tpc_pkg::TPC_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Clock source and debug
  input wire logic external_clock_in,
  input wire logic background_debug_mode,
  // Channel pins and port fallback
  input wire logic [NUM_CH-1:0] channel_pin_in,
  output logic [NUM_CH-1:0] channel_pin_out,
  output logic [NUM_CH-1:0] channel_pin_oe_n,
  output logic [NUM_CH-1:0] channel_timer_en,
  input wire logic [NUM_CH-1:0] port_data,
  input wire logic [NUM_CH-1:0] port_dir,
  // Interrupt
  output logic irq
);
  import tpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, rd_data;
  logic do_write, do_read, cnt_write;

  logic [5:0] sc_q, sc_d;
  logic ovf_q, ovf_d, ovf_arm_q, ovf_arm_d;
  logic [15:0] cnt_q, cnt_d, mod_q, mod_d, limit;
  logic [6:0] pre_q, pre_d, div_last;
  tpc_dir_type dir_q, dir_d;
  logic new_q, new_d, src_edge, tick, ovf_set, center_aligned_pwm;
  logic [3:0] cfg_q [NUM_CH];
  logic [3:0] cfg_d [NUM_CH];
  logic [15:0] val_q [NUM_CH];
  logic [15:0] val_d [NUM_CH];
  logic [NUM_CH-1:0] flag_q, flag_d, arm_q, arm_d;
  logic [8:0] isr_q, isr_d, imr_q, imr_d;
  logic irq_q, irq_d;

  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic [NUM_CH-1:0] pin_s1_q, pin_s2_q;
  logic [NUM_CH-1:0] out_q, out_d, oe_n_q, oe_n_d, en_q, en_d;
  logic [NUM_CH-1:0] ch_evt, ch_lvl, ch_fn, ch_drv;

  assign center_aligned_pwm = sc_q[TPC_SC_CENTER_ALIGNED_PWM_BIT];
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign do_read = arvalid && arready_q;
  assign cnt_write = do_write && (aw_addr_q == TPC_OFS_CNT) && (|w_strb_q[1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  for (genvar g = 0; g < NUM_CH; g++) begin : gen_ch // see R3
    tpc_chan_if cif ();
    assign cif.count = cnt_q;
    assign cif.count_new = new_q;
    assign cif.center_aligned_pwm = center_aligned_pwm;
    assign cif.mode = tpc_mode_type'(cfg_q[g][3:2]);
    assign cif.els = cfg_q[g][1:0];
    assign cif.value = val_q[g];
    assign cif.pin_level = pin_s2_q[g];
    assign ch_evt[g] = cif.event_pulse;
    assign ch_lvl[g] = cif.drive_level;
    assign ch_fn[g] = cif.fn_enable;
    assign ch_drv[g] = cif.drives;
    tpc_channel u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .ch(cif)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (araddr)
      TPC_OFS_SC: rd_data = {24'h00_0000, ovf_q, 1'b0, sc_q};
      // Counter is held while in debug, so this is the frozen value
      TPC_OFS_CNT: rd_data = {16'h0000, cnt_q}; // see R14
      TPC_OFS_MOD: rd_data = {16'h0000, mod_q};
      TPC_OFS_ISR: rd_data = {23'h00_0000, isr_q};
      TPC_OFS_IMR: rd_data = {23'h00_0000, imr_q};
      default: begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (tpc_ch_hit(araddr, i)) begin
            rd_data = araddr[TPC_CH_VAL_BIT] ? {16'h0000, val_q[i]} :
                      {24'h00_0000, flag_q[i], 1'b0, cfg_q[i], 2'b00};
          end
        end
      end
    endcase
  end

  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d = w_full_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (awvalid && awready_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_full_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = tpc_addr_ok(aw_addr_q, NUM_CH) ? TPC_RESP_OKAY : TPC_RESP_SLVERR;
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (do_read) begin
      rvalid_d = 1'b1;
      rdata_d = rd_data;
      rresp_d = tpc_addr_ok(araddr, NUM_CH) ? TPC_RESP_OKAY : TPC_RESP_SLVERR;
    end
    awready_d = !aw_full_d;
    wready_d = !w_full_d;
    arready_d = !rvalid_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, flags and pins
  always_comb begin
    sc_d = sc_q;
    ovf_d = ovf_q;
    ovf_arm_d = ovf_arm_q;
    cnt_d = cnt_q;
    mod_d = mod_q;
    pre_d = pre_q;
    dir_d = dir_q;
    new_d = 1'b0;
    cfg_d = cfg_q;
    val_d = val_q;
    flag_d = flag_q;
    arm_d = arm_q;
    isr_d = isr_q;
    imr_d = imr_q;
    ovf_set = 1'b0;
    // A zero modulo leaves the counter free running
    limit = (mod_q == 16'h0000) ? TPC_CNT_FULL : mod_q;
    unique case (tpc_clk_type'(sc_q[TPC_SC_CLK_LSB +: 2])) // see R4
      TPC_CLK_OFF: src_edge = 1'b0;
      TPC_CLK_BUS, TPC_CLK_BUS_ALT: src_edge = 1'b1;
      TPC_CLK_EXT: src_edge = ext_s2_q && !ext_s3_q; // see R17
    endcase
    div_last = 7'((8'h01 << sc_q[TPC_SC_PS_LSB +: 3]) - 8'h01);
    tick = src_edge && !background_debug_mode && (pre_q == div_last);
    if (src_edge && !background_debug_mode) begin
      pre_d = tick ? 7'h00 : 7'(pre_q + 7'h01);
    end
    if (tick) begin
      new_d = 1'b1;
      if (center_aligned_pwm) begin // see R2
        if (dir_q == TPC_DIR_UP) begin
          if (cnt_q >= limit) begin
            dir_d = TPC_DIR_DOWN;
            cnt_d = 16'(cnt_q - 16'h0001);
            ovf_set = 1'b1; // see R7
          end else begin
            cnt_d = 16'(cnt_q + 16'h0001);
          end
        end else if (cnt_q == 16'h0000) begin
          dir_d = TPC_DIR_UP;
          cnt_d = 16'h0001;
        end else begin
          cnt_d = 16'(cnt_q - 16'h0001);
        end
      end else begin
        dir_d = TPC_DIR_UP;
        if (cnt_q >= limit) begin
          cnt_d = 16'h0000;
          ovf_set = 1'b1; // see R16
        end else begin
          cnt_d = 16'(cnt_q + 16'h0001);
        end
      end
    end
    if (cnt_write) begin
      cnt_d = 16'h0000; // see R13
      pre_d = 7'h00;
      dir_d = TPC_DIR_UP;
      new_d = 1'b1;
    end
    // Register writes, then read side effects, then hardware sets win
    if (do_write) begin
      if (aw_addr_q == TPC_OFS_SC && w_strb_q[0]) begin
        sc_d = w_data_q[5:0];
        if (ovf_arm_q && !w_data_q[TPC_SC_OVF_BIT]) begin
          ovf_d = 1'b0; // see R15
          ovf_arm_d = 1'b0;
        end
      end
      if (aw_addr_q == TPC_OFS_MOD) begin
        mod_d = tpc_merge(mod_q, w_data_q, w_strb_q);
      end
      if (aw_addr_q == TPC_OFS_IMR) begin
        imr_d = 9'(tpc_merge({7'h00, imr_q}, w_data_q, w_strb_q) & 16'h01ff);
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (tpc_ch_hit(aw_addr_q, i)) begin
          if (aw_addr_q[TPC_CH_VAL_BIT]) begin
            val_d[i] = tpc_merge(val_q[i], w_data_q, w_strb_q);
          end else if (w_strb_q[0]) begin
            cfg_d[i] = w_data_q[TPC_CH_ELS_LSB +: 4];
            if (arm_q[i] && !w_data_q[TPC_CH_FLAG_BIT]) begin
              flag_d[i] = 1'b0; // see R12
              arm_d[i] = 1'b0;
            end
          end
        end
      end
    end
    if (do_read) begin
      if (araddr == TPC_OFS_SC && ovf_q) begin
        ovf_arm_d = 1'b1; // see R15
      end
      if (araddr == TPC_OFS_ISR) begin
        isr_d = TPC_IRQ_RESET;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (tpc_ch_hit(araddr, i) && !araddr[TPC_CH_VAL_BIT] && flag_q[i]) begin
          arm_d[i] = 1'b1; // see R12
        end
      end
    end
    // A new event restarts the clearing sequence
    if (ovf_set) begin
      ovf_d = 1'b1; // see R15
      ovf_arm_d = 1'b0;
      isr_d[TPC_ISR_OVF_BIT] = 1'b1;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_evt[i]) begin
        flag_d[i] = 1'b1; // see R12
        arm_d[i] = 1'b0;
        isr_d[i + 1] = 1'b1;
        if (!center_aligned_pwm && tpc_mode_type'(cfg_q[i][3:2]) == TPC_MODE_CAPTURE) begin
          val_d[i] = cnt_q; // see R8
        end
      end
      // Pin reverts to port logic when no function owns it
      en_d[i] = ch_fn[i]; // see R6
      out_d[i] = ch_fn[i] ? ch_lvl[i] : port_data[i]; // see R6
      oe_n_d[i] = ch_fn[i] ? !ch_drv[i] : !port_dir[i]; // see R6
    end
    irq_d = |(isr_d & imr_d);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= TPC_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= TPC_RESP_OKAY;
      sc_q <= TPC_SC_RESET;
      ovf_q <= 1'b0;
      ovf_arm_q <= 1'b0;
      cnt_q <= 16'h0000;
      mod_q <= TPC_MOD_RESET;
      pre_q <= 7'h00;
      dir_q <= TPC_DIR_UP;
      new_q <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_q[i] <= TPC_CH_CFG_RESET; // see R5
        val_q[i] <= 16'h0000;
      end
      flag_q <= '0;
      arm_q <= '0;
      isr_q <= TPC_IRQ_RESET;
      imr_q <= TPC_IRQ_RESET;
      irq_q <= 1'b0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      out_q <= '0;
      oe_n_q <= '1;
      en_q <= '0; // see R5
    end else begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q <= w_full_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      sc_q <= sc_d;
      ovf_q <= ovf_d;
      ovf_arm_q <= ovf_arm_d;
      cnt_q <= cnt_d;
      mod_q <= mod_d;
      pre_q <= pre_d;
      dir_q <= dir_d;
      new_q <= new_d;
      cfg_q <= cfg_d;
      val_q <= val_d;
      flag_q <= flag_d;
      arm_q <= arm_d;
      isr_q <= isr_d;
      imr_q <= imr_d;
      irq_q <= irq_d;
      ext_s1_q <= external_clock_in; // see R17
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      pin_s1_q <= channel_pin_in;
      pin_s2_q <= pin_s1_q;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      en_q <= en_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign channel_pin_out = out_q;
  assign channel_pin_oe_n = oe_n_q;
  assign channel_timer_en = en_q;
  assign irq = irq_q;

endmodule : tpc_timer

/* File: logic/tpc_pkg.sv */
package tpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int TPC_MAX_CH = 8;
  localparam int TPC_AW = 8;
  localparam int TPC_CH_SHIFT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] TPC_OFS_SC = 8'h00;
  localparam logic [7:0] TPC_OFS_CNT = 8'h04;
  localparam logic [7:0] TPC_OFS_MOD = 8'h08;
  localparam logic [7:0] TPC_OFS_ISR = 8'h0c;
  localparam logic [7:0] TPC_OFS_IMR = 8'h10;
  localparam logic [7:0] TPC_OFS_CH_BASE = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int TPC_SC_OVF_BIT = 7;
  localparam int TPC_SC_CENTER_ALIGNED_PWM_BIT = 5;
  localparam int TPC_SC_CLK_LSB = 3;
  localparam int TPC_SC_PS_LSB = 0;
  localparam int TPC_CH_FLAG_BIT = 7;
  localparam int TPC_CH_MODE_LSB = 4;
  localparam int TPC_CH_ELS_LSB = 2;
  localparam int TPC_CH_VAL_BIT = 2;
  localparam int TPC_ISR_OVF_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and constants
  localparam logic [5:0] TPC_SC_RESET = 6'h00;
  localparam logic [3:0] TPC_CH_CFG_RESET = 4'h0;
  localparam logic [15:0] TPC_MOD_RESET = 16'h0000;
  localparam logic [15:0] TPC_CNT_FULL = 16'hffff;
  localparam logic [8:0] TPC_IRQ_RESET = 9'h000;
  localparam logic [1:0] TPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TPC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TPC_MODE_CAPTURE = 2'b00,
    TPC_MODE_COMPARE = 2'b01,
    TPC_MODE_EDGE_ALIGNED_PWM = 2'b10,
    TPC_MODE_EDGE_ALIGNED_PWM_ALT = 2'b11
  } tpc_mode_type;

  typedef enum logic [1:0] {
    TPC_CLK_OFF = 2'b00,
    TPC_CLK_BUS = 2'b01,
    TPC_CLK_EXT = 2'b10,
    TPC_CLK_BUS_ALT = 2'b11
  } tpc_clk_type;

  typedef enum logic {
    TPC_DIR_UP = 1'b0,
    TPC_DIR_DOWN = 1'b1
  } tpc_dir_type;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] tpc_merge(input logic [15:0] old, input logic [31:0] wdata,
                                            input logic [3:0] wstrb);
    tpc_merge = {wstrb[1] ? wdata[15:8] : old[15:8], wstrb[0] ? wdata[7:0] : old[7:0]};
  endfunction : tpc_merge

  function automatic logic tpc_ch_hit(input logic [7:0] addr, input int idx);
    logic [7:0] rel;
    rel = addr - TPC_OFS_CH_BASE;
    tpc_ch_hit = (addr >= TPC_OFS_CH_BASE) && (addr[1:0] == 2'h0) && (rel[7:3] == 5'(idx));
  endfunction : tpc_ch_hit

  function automatic logic tpc_addr_ok(input logic [7:0] addr, input int nch);
    logic ok;
    ok = (addr == TPC_OFS_SC) || (addr == TPC_OFS_CNT) || (addr == TPC_OFS_MOD) ||
         (addr == TPC_OFS_ISR) || (addr == TPC_OFS_IMR);
    for (int i = 0; i < nch; i++) begin
      ok = ok || tpc_ch_hit(addr, i);
    end
    tpc_addr_ok = ok;
  endfunction : tpc_addr_ok

endpackage : tpc_pkg

/* File: logic/tpc_chan_if.sv */
`timescale 1ns/10ps
interface tpc_chan_if;
  import tpc_pkg::*;
  logic [15:0] count;
  logic count_new;
  logic center_aligned_pwm;
  tpc_mode_type mode;
  logic [1:0] els;
  logic [15:0] value;
  logic pin_level;
  logic event_pulse;
  logic drive_level;
  logic fn_enable;
  logic drives;

  modport timer (
    output count, count_new, center_aligned_pwm, mode, els, value, pin_level,
    input event_pulse, drive_level, fn_enable, drives
  );
  modport channel (
    input count, count_new, center_aligned_pwm, mode, els, value, pin_level,
    output event_pulse, drive_level, fn_enable, drives
  );
endinterface : tpc_chan_if

/* File: logic/tpc_channel.sv */
`timescale 1ns/10ps
module tpc_channel (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Timer side
  tpc_chan_if.channel ch
);
  import tpc_pkg::*;

  logic prev_q;
  logic prev_d;
  logic level_q;
  logic level_d;
  logic event_q;
  logic event_d;
  logic match;

  assign match = ch.count_new && (ch.count == ch.value);
  // Edge select of zero means the pin is not used at all
  assign ch.fn_enable = (ch.els != 2'b00); // see R6
  assign ch.drives = ch.fn_enable && (ch.center_aligned_pwm || (ch.mode != TPC_MODE_CAPTURE));
  assign ch.event_pulse = event_q;
  assign ch.drive_level = level_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    prev_d = ch.pin_level;
    level_d = level_q;
    event_d = 1'b0;
    if (ch.center_aligned_pwm) begin
      // Matches on the way up and on the way down
      if (ch.count_new) begin
        event_d = match; // see R11
        level_d = (ch.count < ch.value) ^ ch.els[0];
      end
    end else begin
      unique case (ch.mode) // see R1
        TPC_MODE_CAPTURE: begin
          unique case (ch.els) // see R8
            2'b01: event_d = ch.pin_level && !prev_q;
            2'b10: event_d = !ch.pin_level && prev_q;
            2'b11: event_d = ch.pin_level ^ prev_q;
            2'b00: event_d = 1'b0;
          endcase
        end
        TPC_MODE_COMPARE: begin
          if (match) begin
            event_d = 1'b1; // see R9
            unique case (ch.els)
              2'b01: level_d = !level_q;
              2'b10: level_d = 1'b0;
              2'b11: level_d = 1'b1;
              2'b00: level_d = level_q;
            endcase
          end
        end
        TPC_MODE_EDGE_ALIGNED_PWM, TPC_MODE_EDGE_ALIGNED_PWM_ALT: begin
          // Match outranks period start so a zero duty stays inactive
          if (match) begin
            event_d = 1'b1; // see R10
            level_d = ch.els[0];
          end else if (ch.count_new && (ch.count == 16'h0000)) begin
            level_d = !ch.els[0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
      level_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      level_q <= level_d;
      event_q <= event_d;
    end
  end

endmodule : tpc_channel

/* File: testbench/tpc_timer_chk.sv */
`timescale 1ns/10ps
module tpc_timer_chk #(
  parameter int NUM_CH = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [tpc_pkg::TPC_AW-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Pins
  input wire logic [NUM_CH-1:0] port_data,
  input wire logic [NUM_CH-1:0] port_dir,
  input wire logic [NUM_CH-1:0] channel_pin_out,
  input wire logic [NUM_CH-1:0] channel_pin_oe_n,
  input wire logic [NUM_CH-1:0] channel_timer_en,
  input wire logic irq
);
  import tpc_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before taken");
  chk_read_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  chk_write_latency: assert property (awvalid && awready && wvalid && wready && !bvalid
    |-> ##2 bvalid) else $error("write response late");
  chk_unmapped_read: assert property (arvalid && arready && araddr == 8'h14
    |=> rresp == TPC_RESP_SLVERR && rdata == 32'h0) else $error("unmapped read answered");
  chk_gpio_fallback: assert property ($past(aresetn) && channel_timer_en == '0 &&
    $past(channel_timer_en) == '0 |-> channel_pin_out == $past(port_data) &&
    channel_pin_oe_n == ~$past(port_dir)) else $error("free pin not under port control");
  chk_reset_idle: assert property (@(posedge aclk) disable iff (1'b0) !aresetn
    |=> channel_timer_en == '0 && &channel_pin_oe_n && !irq) else $error("reset not idle");
  cov_irq: cover property ($rose(irq));
  cov_slverr: cover property (bvalid && bready && bresp == TPC_RESP_SLVERR);
  cov_pin_owned: cover property (channel_timer_en != '0);
endmodule : tpc_timer_chk

bind tpc_timer tpc_timer_chk #(.NUM_CH(NUM_CH)) u_chk (.*);

/* File: testbench/tpc_pins_model.sv */
`timescale 1ns/10ps
module tpc_pins_model #(
  parameter int N = 8
) (
  // Bench control
  input wire logic ext_run,
  input wire logic [N-1:0] cap_level,
  // Timer pins
  input wire logic [N-1:0] channel_pin_out,
  input wire logic [N-1:0] channel_pin_oe_n,
  output logic external_clock_in,
  output logic [N-1:0] channel_pin_in
);
  // Toggles on falling bus edges, two bus cycles per phase so no edge is lost
  initial begin
    external_clock_in = 1'b0;
    forever begin
      #80;
      external_clock_in = ext_run ? ~external_clock_in : 1'b0;
    end
  end
  // Driver wins the wire, else the outside source
  assign channel_pin_in = (channel_pin_out & ~channel_pin_oe_n) | (cap_level & channel_pin_oe_n);
endmodule : tpc_pins_model

/* File: testbench/tpc_timer_tb.sv */
`timescale 1ns/10ps
module tpc_timer_tb;
  import tpc_pkg::*;
  localparam int NCH = 4;
  localparam logic [7:0] CH0 = TPC_OFS_CH_BASE;
  localparam logic [7:0] CH1 = TPC_OFS_CH_BASE + 8'h08;
  localparam logic [7:0] CH2 = TPC_OFS_CH_BASE + 8'h10;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, irq, external_clock_in, background_debug_mode, ext_run;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [NCH-1:0] channel_pin_in, channel_pin_out, channel_pin_oe_n, channel_timer_en;
  logic [NCH-1:0] port_data, port_dir, cap_level;
  int bad_count, cmp_count;
  tpc_timer #(.NUM_CH(NCH)) DUT (.*);
  tpc_pins_model #(.N(NCH)) pins (.*);
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] e, input string what);
    cmp_count++;
    if (seen !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, seen);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    check(r, er, "bresp");
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
    logic ta, tr;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
    check(r, er, "rresp");
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic [31:0] d;
    rd(a, d, er);
    check(d, e, $sformatf("reg %h", a));
  endtask : rdc
  task automatic count_high(input int k, input int e, input string what);
    logic [31:0] h;
    h = 32'h0;
    repeat (k) begin
      @(negedge aclk);
      h = h + 32'(channel_pin_out[1]);
    end
    check(h, e, what);
  endtask : count_high
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, background_debug_mode, ext_run} = '0;
    {awaddr, araddr, wdata, port_data, port_dir, cap_level} = '0;
    wstrb = 4'hf;
    bad_count = 0;
    cmp_count = 0;
    cyc(12);
    aresetn <= 1'b1;
    rdc(TPC_OFS_SC, 32'h0);
    check(channel_timer_en, 32'h0, "timer_en");
    port_data <= 4'ha;
    port_dir <= 4'h5;
    cyc(2);
    check(channel_pin_out, 32'ha, "pin_out");
    check(channel_pin_oe_n, 32'ha, "pin_oe_n");
    rdc(8'h14, 32'h0, TPC_RESP_SLVERR);
    rdc(TPC_OFS_CH_BASE + 8'(8 * NCH), 32'h0, TPC_RESP_SLVERR);
    wr(8'h14, 32'h1, TPC_RESP_SLVERR);
    wr(TPC_OFS_MOD, 32'h9);
    wr(TPC_OFS_SC, 32'h08);
    cyc(30);
    // Zero written before arming must not clear
    wr(TPC_OFS_SC, 32'h0);
    check(irq, 32'h0, "irq masked");
    rdc(TPC_OFS_SC, 32'h80);
    wr(TPC_OFS_SC, 32'h0);
    rdc(TPC_OFS_SC, 32'h0);
    wr(TPC_OFS_IMR, 32'h1);
    cyc(2);
    check(irq, 32'h1, "irq");
    rdc(TPC_OFS_ISR, 32'h1);
    cyc(2);
    check(irq, 32'h0, "irq cleared");
    rd(TPC_OFS_CNT, rv);
    check(rv < 10, 32'h1, "count below modulo");
    wr(TPC_OFS_SC, 32'h08);
    background_debug_mode <= 1'b1;
    rd(TPC_OFS_CNT, rv);
    cyc(3);
    rdc(TPC_OFS_CNT, rv);
    background_debug_mode <= 1'b0;
    wr(TPC_OFS_SC, 32'h0);
    wr(TPC_OFS_CNT, 32'h1234);
    rdc(TPC_OFS_CNT, 32'h0);
    wr(TPC_OFS_MOD, 32'hf);
    wr(CH0 + 8'h4, 32'h5);
    wr(CH0, 32'h14);
    cyc(2);
    check({channel_timer_en[0], channel_pin_oe_n[0]}, 32'h2, "ch0 owns pin");
    wr(TPC_OFS_SC, 32'h08);
    cyc(40);
    wr(TPC_OFS_SC, 32'h0);
    wr(CH0, 32'h14);
    rdc(CH0, 32'h94);
    wr(CH0, 32'h14);
    rdc(CH0, 32'h14);
    wr(TPC_OFS_MOD, 32'h9);
    wr(CH1 + 8'h4, 32'h4);
    wr(CH1, 32'h28);
    wr(TPC_OFS_SC, 32'h08);
    cyc(12);
    count_high(40, 16, "edge duty");
    wr(TPC_OFS_SC, 32'h0);
    rdc(CH1, 32'ha8);
    wr(CH1, 32'h28);
    wr(TPC_OFS_MOD, 32'h8);
    wr(CH1 + 8'h4, 32'h3);
    rd(TPC_OFS_SC, rv);
    wr(TPC_OFS_SC, 32'h28);
    cyc(20);
    count_high(32, 10, "center duty");
    wr(TPC_OFS_SC, 32'h0);
    rdc(TPC_OFS_SC, 32'h80);
    rdc(CH1, 32'ha8);
    for (int e = 1; e < 4; e++) begin
      wr(CH2, 32'(e) << 2);
      cyc(2);
      check({channel_timer_en[2], channel_pin_oe_n[2]}, 32'h3, "ch2 input");
      cap_level[2] <= 1'b1;
      cyc(8);
      rdc(CH2, (32'(e) << 2) | (e[0] ? 32'h80 : 32'h0));
      wr(CH2, 32'(e) << 2);
      cap_level[2] <= 1'b0;
      cyc(8);
      rdc(CH2, (32'(e) << 2) | (e[1] ? 32'h80 : 32'h0));
      wr(CH2, 32'(e) << 2);
    end
    wr(CH2, 32'h0);
    cyc(2);
    check(channel_timer_en[2], 32'h0, "ch2 released");
    wr(TPC_OFS_MOD, 32'h0);
    wr(TPC_OFS_SC, 32'h10);
    wr(TPC_OFS_CNT, 32'h0);
    ext_run <= 1'b1;
    cyc(70);
    ext_run <= 1'b0;
    cyc(4);
    rd(TPC_OFS_CNT, rv);
    check(rv > 16 && rv < 20, 32'h1, "external count");
    rdc(TPC_OFS_CNT, rv);
    complete_run();
  end
endmodule : tpc_timer_tb
